/* rtl/cst_cfg.svh */
// constants of the bus error and transfer status register block
`ifndef CST_CFG_SVH
`define CST_CFG_SVH
`define CST_OFS_STATUS    4'h4
`define CST_OFS_IRQ_ID    4'h8
`define CST_OFS_CTRL      4'hC
`define CST_OFS_INT_STAT  4'h0
`define CST_OFS_INT_CLR   4'h1
`define CST_OFS_INT_EN    4'h2
`define CST_BIT_BUSOFF    7
`define CST_BIT_WARN      6
`define CST_BIT_PASSIVE   5
`define CST_BIT_RX_SUCCESS_FLAG      4
`define CST_BIT_TX_SUCCESS_FLAG      3
`define CST_WARN_LIMIT    8'h60
`define CST_STATUS_RST    16'h0000
`define CST_IRQ_STATUS_ID 16'h8000
`define CST_RECESS_RUN    4'hB
`define CST_CTRL_EIE      3
`define CST_CTRL_SIE      2
`define CST_CTRL_IE       1
`endif

/* rtl/cst_pkg.sv */
// types of the bus error and transfer status register block
package cst_pkg;
  typedef enum logic [2:0] {
    CST_LEC_NONE      = 3'h0,
    CST_LEC_STUFF     = 3'h1,
    CST_LEC_FORM      = 3'h2,
    CST_LEC_ACK       = 3'h3,
    CST_LEC_RECESSIVE = 3'h4,
    CST_LEC_DOMINANT  = 3'h5,
    CST_LEC_CRC       = 3'h6,
    CST_LEC_UNUSED    = 3'h7
  } cst_lec_t;

  // conditions from the error management logic
  typedef struct packed {
    logic       busoff;
    logic       recovering;
    logic [7:0] tx_err_cnt;
    logic [7:0] rx_err_cnt;
    logic       passive;
  } cst_eml_t;

  // protocol engine events, each a one-cycle pulse
  typedef struct packed {
    logic     rx_ok;
    logic     tx_ok;
    logic     err;
    cst_lec_t err_code;
    logic     bit_valid;
    logic     bit_recessive;
  } cst_evt_t;

  typedef struct packed {
    logic        busoff_flag;
    logic        warning_limit_flag;
    logic        error_passive_flag;
    logic        rx_success_flag;
    logic        tx_success_flag;
    cst_lec_t    last_error_code;
    logic [3:0]  recess_cnt;
    logic [15:0] irq_id;
    logic [3:0]  ctrl;
    logic [2:0]  int_stat;
    logic [2:0]  int_en;
    logic [15:0] rdata;
    logic        irq;
  } cst_state_t;
endpackage

/* rtl/cst_status.sv */
// bus error and transfer status register with its interrupt logic
//
// Function
// RULE_01: bits 15 to 8 read zero and software writes only zero there.
// RULE_02: bit 7 reads one exactly while the controller is busoff.
// RULE_03: bit 6 is one while either error counter is at 96 or more.
// RULE_04: bit 5 is one while the core is error passive.
// RULE_05: bit 4 sets on every error-free reception, filtered or not.
// RULE_06: the core never clears bit 4; only a processor write does.
// RULE_07: bit 3 sets on acknowledged error-free transmission only.
// RULE_08: bits 2 to 0 hold the code of the most recent bus error.
// RULE_09: the error code clears to zero on any error-free transfer.
// RULE_10: software may load code seven, kept until a bus event.
// RULE_11: codes are 1 stuff, 2 form, 3 ack, 4 and 5 bit faults, 6 crc.
// RULE_12: in busoff recovery each run of 11 recessive bits loads code 5.
// RULE_13: flag changes raise error or status change interrupts if enabled; a passive flag change raises neither.
// RULE_14: reading the status register clears a pending id of 8000h.
// RULE_15: processor writes reach only the success flags and error code.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`include "cst_cfg.svh"

module cst_status (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // register port
  input  wire logic [3:0]    addr,
  input  wire logic [15:0]   wdata,
  input  wire logic          wr,
  input  wire logic          rd,
  output logic      [15:0]   rdata,
  // core side
  input  wire cst_pkg::cst_eml_t error_management_logic,
  input  wire cst_pkg::cst_evt_t evt,
  // interrupt
  output logic               irq
);
  import cst_pkg::*;

  cst_state_t st_ff;
  cst_state_t nxt_st;
  logic       warn_now;
  logic       lec_evt;
  logic       err_chg;
  logic       st_chg;
  logic       run_done;
  logic [2:0] raised;

  // live conditions and events
  always_comb begin
    warn_now = (error_management_logic.tx_err_cnt >= `CST_WARN_LIMIT) ||
               (error_management_logic.rx_err_cnt >= `CST_WARN_LIMIT);       // RULE_03
    run_done = error_management_logic.recovering && evt.bit_valid && evt.bit_recessive &&
               (st_ff.recess_cnt == `CST_RECESS_RUN - 4'h1); // RULE_12
    lec_evt  = evt.err || evt.rx_ok || evt.tx_ok || run_done;
    err_chg  = (error_management_logic.busoff != st_ff.busoff_flag) ||
               (warn_now != st_ff.warning_limit_flag);     // RULE_13
    st_chg   = evt.rx_ok || evt.tx_ok || lec_evt;          // RULE_13
    raised   = {1'b0, st_chg, err_chg};
  end

  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.busoff_flag        = error_management_logic.busoff;                // RULE_02
    nxt_st.warning_limit_flag = warn_now;                  // RULE_03
    nxt_st.error_passive_flag = error_management_logic.passive;               // RULE_04
    // recessive run counter during busoff recovery
    if (!error_management_logic.recovering || (evt.bit_valid && !evt.bit_recessive)) begin
      nxt_st.recess_cnt = 4'h0;
    end else if (evt.bit_valid) begin
      nxt_st.recess_cnt = run_done ? 4'h0 : st_ff.recess_cnt + 4'h1;
    end
    // processor write: success flags and error code only
    if (wr && addr == `CST_OFS_STATUS) begin               // RULE_15
      nxt_st.rx_success_flag = wdata[`CST_BIT_RX_SUCCESS_FLAG];
      nxt_st.tx_success_flag = wdata[`CST_BIT_TX_SUCCESS_FLAG];
      nxt_st.last_error_code = cst_lec_t'(wdata[2:0]);     // RULE_10
    end
    // core events win over a same-cycle write
    if (evt.rx_ok) begin
      nxt_st.rx_success_flag = 1'b1;                       // RULE_05 RULE_06
    end
    if (evt.tx_ok) begin
      nxt_st.tx_success_flag = 1'b1;                       // RULE_07
    end
    if (evt.rx_ok || evt.tx_ok) begin
      nxt_st.last_error_code = CST_LEC_NONE;               // RULE_09
    end
    if (evt.err) begin
      nxt_st.last_error_code = evt.err_code;               // RULE_08 RULE_11
    end
    if (run_done) begin
      nxt_st.last_error_code = CST_LEC_DOMINANT;           // RULE_12
    end
    // control register and interrupt block
    if (wr && addr == `CST_OFS_CTRL) begin
      nxt_st.ctrl = wdata[3:0];
    end
    if (wr && addr == `CST_OFS_INT_EN) begin
      nxt_st.int_en = wdata[2:0];
    end
    if (wr && addr == `CST_OFS_INT_CLR) begin
      nxt_st.int_stat = st_ff.int_stat & ~wdata[2:0];
    end
    nxt_st.int_stat = nxt_st.int_stat | raised;
    // interrupt identifier
    if (rd && addr == `CST_OFS_STATUS &&
        st_ff.irq_id == `CST_IRQ_STATUS_ID) begin
      nxt_st.irq_id = 16'h0000;                            // RULE_14
    end
    if ((err_chg && st_ff.ctrl[`CST_CTRL_EIE]) ||
        (st_chg && st_ff.ctrl[`CST_CTRL_SIE])) begin       // RULE_13
      nxt_st.irq_id = `CST_IRQ_STATUS_ID;
    end
    // read data one cycle after the strobe
    nxt_st.rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        `CST_OFS_STATUS:   nxt_st.rdata = {8'h00,              // RULE_01
                             st_ff.busoff_flag, st_ff.warning_limit_flag,
                             st_ff.error_passive_flag, st_ff.rx_success_flag,
                             st_ff.tx_success_flag, st_ff.last_error_code};
        `CST_OFS_IRQ_ID:   nxt_st.rdata = st_ff.irq_id;
        `CST_OFS_CTRL:     nxt_st.rdata = {12'h000, st_ff.ctrl};
        `CST_OFS_INT_STAT: nxt_st.rdata = {13'h0, st_ff.int_stat};
        `CST_OFS_INT_EN:   nxt_st.rdata = {13'h0, st_ff.int_en};
        default:           nxt_st.rdata = 16'h0000;
      endcase
    end
    nxt_st.irq = |(nxt_st.int_stat & nxt_st.int_en);
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign irq   = st_ff.irq;

  AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    $past(rd) && $past(addr) == `CST_OFS_STATUS |-> rdata[15:8] == 8'h00)
    else $error("reserved status bits not zero"); // RULE_01
  AST_BUSOFF: assert property (@(posedge clk_sys) disable iff (rst)
    st_ff.busoff_flag == $past(error_management_logic.busoff))
    else $error("busoff flag does not follow core"); // RULE_02
  AST_WARN: assert property (@(posedge clk_sys) disable iff (rst)
    $past(error_management_logic.tx_err_cnt) == 8'h60 |-> st_ff.warning_limit_flag)
    else $error("warning flag missed limit"); // RULE_03
  AST_PASSIVE: assert property (@(posedge clk_sys) disable iff (rst)
    st_ff.error_passive_flag == $past(error_management_logic.passive))
    else $error("passive flag wrong"); // RULE_04
  AST_RX_SUCCESS_FLAG_SET: assert property (@(posedge clk_sys) disable iff (rst)
    evt.rx_ok |=> st_ff.rx_success_flag)
    else $error("rx success not set"); // RULE_05
  AST_RX_SUCCESS_FLAG_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    st_ff.rx_success_flag && !(wr && addr == `CST_OFS_STATUS)
    |=> st_ff.rx_success_flag)
    else $error("rx success cleared by core"); // RULE_06
  AST_TX_SUCCESS_FLAG_SET: assert property (@(posedge clk_sys) disable iff (rst)
    evt.tx_ok |=> st_ff.tx_success_flag)
    else $error("tx success not set"); // RULE_07
  AST_LEC_CLR: assert property (@(posedge clk_sys) disable iff (rst)
    (evt.rx_ok || evt.tx_ok) && !evt.err && !run_done
    |=> st_ff.last_error_code == CST_LEC_NONE)
    else $error("error code not cleared"); // RULE_09
  AST_LEC_SEVEN: assert property (@(posedge clk_sys) disable iff (rst)
    st_ff.last_error_code == CST_LEC_UNUSED && !lec_evt && !wr
    |=> st_ff.last_error_code == CST_LEC_UNUSED)
    else $error("code seven lost"); // RULE_10
  AST_RECOVERY: assert property (@(posedge clk_sys) disable iff (rst)
    run_done |=> st_ff.last_error_code == CST_LEC_DOMINANT)
    else $error("recovery code missing"); // RULE_12
  AST_IRQ_ID_CLR: assert property (@(posedge clk_sys) disable iff (rst)
    rd && addr == `CST_OFS_STATUS && !err_chg && !st_chg
    |=> st_ff.irq_id != `CST_IRQ_STATUS_ID)
    else $error("status id not cleared by read"); // RULE_14
  AST_RO_FLAGS: assert property (@(posedge clk_sys) disable iff (rst)
    wr && addr == `CST_OFS_STATUS |=> st_ff.busoff_flag == $past(error_management_logic.busoff))
    else $error("write reached busoff flag"); // RULE_15

  // read port: data only in the cycle after a strobe
  AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
    !$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside its cycle"); // RULE_01

  AST_RDATA_UNMAPPED: assert property (@(posedge clk_sys) disable iff (rst)
    $past(rd) && $past(addr) == 4'h3 |-> rdata == 16'h0000)
    else $error("unmapped index returned data"); // RULE_01

  // warning flag against both counters
  AST_WARN_RX: assert property (@(posedge clk_sys) disable iff (rst)
    $past(error_management_logic.rx_err_cnt) >= 8'h60 |-> st_ff.warning_limit_flag)
    else $error("warning flag missed rx limit"); // RULE_03

  AST_WARN_LOW: assert property (@(posedge clk_sys) disable iff (rst)
    $past(error_management_logic.tx_err_cnt) < 8'h60 && $past(error_management_logic.rx_err_cnt) < 8'h60
    |-> !st_ff.warning_limit_flag)
    else $error("warning flag set below limit"); // RULE_03

  // success flags: set by the core, cleared only by software
  AST_RX_SUCCESS_FLAG_CLR_WR: assert property (@(posedge clk_sys) disable iff (rst)
    wr && addr == `CST_OFS_STATUS && !wdata[`CST_BIT_RX_SUCCESS_FLAG] && !evt.rx_ok
    |=> !st_ff.rx_success_flag)
    else $error("rx success not cleared by write"); // RULE_06

  AST_TX_SUCCESS_FLAG_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    st_ff.tx_success_flag && !(wr && addr == `CST_OFS_STATUS)
    |=> st_ff.tx_success_flag)
    else $error("tx success cleared by core"); // RULE_07

  AST_TX_SUCCESS_FLAG_NOSET: assert property (@(posedge clk_sys) disable iff (rst)
    !st_ff.tx_success_flag && !evt.tx_ok && !(wr && addr == `CST_OFS_STATUS)
    |=> !st_ff.tx_success_flag)
    else $error("tx success set without transfer"); // RULE_07

  // error code field
  AST_LEC_ERR: assert property (@(posedge clk_sys) disable iff (rst)
    evt.err && !run_done
    |=> st_ff.last_error_code == $past(evt.err_code))
    else $error("error code not loaded"); // RULE_08 RULE_11

  AST_LEC_WR: assert property (@(posedge clk_sys) disable iff (rst)
    wr && addr == `CST_OFS_STATUS && !lec_evt
    |=> st_ff.last_error_code == cst_lec_t'($past(wdata[2:0])))
    else $error("error code write lost"); // RULE_10 RULE_15

  // recovery run counter
  AST_RECESS_CNT: assert property (@(posedge clk_sys) disable iff (rst)
    st_ff.recess_cnt <= `CST_RECESS_RUN - 4'h1)
    else $error("recessive run counter overran"); // RULE_12

  AST_RUN_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
    !error_management_logic.recovering |=> st_ff.recess_cnt == 4'h0)
    else $error("run counter moved outside recovery"); // RULE_12

  // interrupt raising, clearing and output level
  AST_ERR_RAISE: assert property (@(posedge clk_sys) disable iff (rst)
    err_chg |=> st_ff.int_stat[0])
    else $error("error interrupt not raised"); // RULE_13

  AST_ST_RAISE: assert property (@(posedge clk_sys) disable iff (rst)
    st_chg |=> st_ff.int_stat[1])
    else $error("status change interrupt not raised"); // RULE_13

  AST_NO_RAISE: assert property (@(posedge clk_sys) disable iff (rst)
    !err_chg && !st_chg && !(wr && addr == `CST_OFS_INT_CLR)
    |=> st_ff.int_stat == $past(st_ff.int_stat))
    else $error("interrupt raised without cause"); // RULE_13

  AST_INT_CLR: assert property (@(posedge clk_sys) disable iff (rst)
    wr && addr == `CST_OFS_INT_CLR && !err_chg && !st_chg
    |=> (st_ff.int_stat & $past(wdata[2:0])) == 3'h0)
    else $error("interrupt clear ignored"); // RULE_13

  AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (rst)
    irq == |(st_ff.int_stat & st_ff.int_en))
    else $error("irq level wrong"); // RULE_13

  AST_IRQ_ID_SET: assert property (@(posedge clk_sys) disable iff (rst)
    st_chg && st_ff.ctrl[`CST_CTRL_SIE]
    |=> st_ff.irq_id == `CST_IRQ_STATUS_ID)
    else $error("status id not set"); // RULE_13

  AST_RO_PASSIVE: assert property (@(posedge clk_sys) disable iff (rst)
    wr && addr == `CST_OFS_STATUS
    |=> st_ff.error_passive_flag == $past(error_management_logic.passive))
    else $error("write reached passive flag"); // RULE_15

  // main scenarios reached
  COV_LEC_SEVEN: cover property (@(posedge clk_sys) disable iff (rst)
    st_ff.last_error_code == CST_LEC_UNUSED);
  COV_ID_CLR: cover property (@(posedge clk_sys) disable iff (rst)
    rd && addr == `CST_OFS_STATUS && st_ff.irq_id == `CST_IRQ_STATUS_ID);

  COV_RX: cover property (@(posedge clk_sys) disable iff (rst)
    evt.rx_ok ##1 st_ff.rx_success_flag);
  COV_RECOVERY: cover property (@(posedge clk_sys) disable iff (rst) run_done);
  COV_IRQ: cover property (@(posedge clk_sys) disable iff (rst) irq);
endmodule

/* sim/cst_node_model.sv */
// behavioural model of the bus nodes and core feeding the status block
`timescale 1ns/10ps

module cst_node_model (
  // clock
  input  wire logic        clk_sys,
  // toward the status block
  output cst_pkg::cst_eml_t error_management_logic,
  output cst_pkg::cst_evt_t evt
);
  import cst_pkg::*;

  // idle: no condition, no event
  initial begin
    error_management_logic = '0;
    evt = '0;
  end

  // error management levels change just after an edge
  task automatic cond(input cst_eml_t c);
    @(posedge clk_sys);
    error_management_logic <= c;
  endtask

  // one-cycle event pulse, then a quiet cycle
  task automatic pulse(input cst_evt_t e);
    @(posedge clk_sys);
    evt <= e;
    @(posedge clk_sys);
    evt <= '0;
  endtask
endmodule

/* sim/tb_top.sv */
// self-checking bench for the status register block
`timescale 1ns/10ps
`include "cst_cfg.svh"

module tb_top;
  import cst_pkg::*;
  localparam logic [3:0] ST = `CST_OFS_STATUS;
  logic        clk_sys = 0;
  logic        rst = 1;
  logic [3:0]  addr = '0;
  logic [15:0] wdata = '0;
  logic        wr = 0;
  logic        rd = 0;
  logic [15:0] rdata;
  logic        irq;
  cst_eml_t    error_management_logic;
  cst_evt_t    evt;
  int          miscompares = 0;
  int          tests_run = 0;
  // rows: busoff, tx count, rx count, passive, expected status
  logic [33:0] rows [5] = '{{1'b1, 8'h00, 8'h00, 1'b0, 16'h0080},
                            {1'b0, 8'h60, 8'h00, 1'b0, 16'h0040},
                            {1'b0, 8'h00, 8'h5F, 1'b0, 16'h0000},
                            {1'b0, 8'h5F, 8'h60, 1'b1, 16'h0060},
                            {1'b1, 8'hFF, 8'h00, 1'b1, 16'h00E0}};

  cst_status i_cst_status (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .error_management_logic(error_management_logic),
    .evt(evt), .irq(irq));
  cst_node_model i_cst_node_model (.clk_sys(clk_sys), .error_management_logic(error_management_logic),
    .evt(evt));

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // read strobe one cycle, data checked in the following cycle
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    {rd, addr} <= {1'b1, a};
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic ev(input logic [7:0] e);
    i_cst_node_model.pulse(e);
  endtask

  task automatic conclude;
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // watchdog
  initial begin
    #40000;
    miscompares++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(ST, 16'h0000);
    // condition flags table
    foreach (rows[i]) begin
      i_cst_node_model.cond({rows[i][33], 1'b0, rows[i][32:16]});
      rd_chk(ST, rows[i][15:0]);
    end
    i_cst_node_model.cond('0);
    wr_reg(ST, 16'h00FF);
    rd_chk(ST, 16'h001F);
    wr_reg(ST, 16'h0007);
    repeat (5) @(posedge clk_sys);
    rd_chk(ST, 16'h0007);
    ev({3'b001, 3'h3, 2'b00});
    rd_chk(ST, 16'h0003);
    ev(8'h80);
    rd_chk(ST, 16'h0010);
    ev({3'b001, 3'h1, 2'b00});
    rd_chk(ST, 16'h0011);
    ev(8'h40);
    rd_chk(ST, 16'h0018);
    for (int c = 1; c < 7; c++) begin
      ev({3'b001, c[2:0], 2'b00});
      rd_chk(ST, 16'h0018 | 16'(c));
    end
    // busoff recovery: ten recessive bits, then the eleventh
    wr_reg(ST, 16'h0000);
    i_cst_node_model.cond(19'h20000);
    repeat (10) ev(8'h03);
    rd_chk(ST, 16'h0000);
    ev(8'h03);
    rd_chk(ST, 16'h0005);
    // interrupts: enable, raise, clear by read, mask
    i_cst_node_model.cond('0);
    wr_reg(`CST_OFS_CTRL, 16'h000E);
    wr_reg(`CST_OFS_INT_CLR, 16'h0007);
    wr_reg(`CST_OFS_INT_EN, 16'h0003);
    wr_reg(ST, 16'h0000);
    #1 chk(irq, 1'b0);
    ev(8'h80);
    #1 chk(irq, 1'b1);
    rd_chk(`CST_OFS_IRQ_ID, `CST_IRQ_STATUS_ID);
    rd_chk(ST, 16'h0010);
    rd_chk(`CST_OFS_IRQ_ID, 16'h0000);
    wr_reg(`CST_OFS_INT_CLR, 16'h0007);
    i_cst_node_model.cond(19'h00001);
    rd_chk(`CST_OFS_INT_STAT, 16'h0000);
    i_cst_node_model.cond(19'h0C000);
    rd_chk(`CST_OFS_INT_STAT, 16'h0001);
    wr_reg(`CST_OFS_INT_EN, 16'h0000);
    #1 chk(irq, 1'b0);
    rd_chk(4'h3, 16'h0000);
    // second reset mid-run, core quiet across the release
    i_cst_node_model.cond('0);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(ST, 16'h0000);
    conclude();
  end
endmodule
